// file: design/mrre_core.sv
// Top of the move/return/rotate execution block: AHB-Lite slave, working
// register, flags, program counter, call stack and 128-byte file.
// Assumes one AHB-Lite master issuing single word transfers on hclk.
//
// Implementation choices: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps

module mrre_core
   import mrre_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp
);

   ////////////////////////////////////////////////////////////////////////////////
   // Declarations
   mrre_state_t state_q;
   logic dphase_q;
   logic dwrite_q;
   mrre_reg_t dreg_q;
   logic rd_wait_q;
   logic [31:0] hrdata_q;
   logic [DATA_W-1:0] work_q;
   logic carry_q;
   logic zero_q;
   logic irq_en_q;
   logic [PC_W-1:0] pc_q;
   logic [SP_W-1:0] sp_q;
   logic [PC_W-1:0] stack_q [STACK_DEPTH];
   logic [DATA_W-1:0] file_q [FILE_DEPTH];
   logic [FILE_ADDR_W-1:0] faddr_q;
   logic addr_take;
   logic wr_done;
   logic exec_go;
   logic sw_wr;
   mrre_instr_t instr;
   mrre_exec_t fx;
   logic [FILE_ADDR_W-1:0] exec_addr;
   logic [STACK_IDX_W-1:0] top_idx;
   logic [PC_W-1:0] stack_top;
   logic stack_empty;
   logic stack_full;
   logic [31:0] rd_mux;
   logic [31:0] status_word;

   ////////////////////////////////////////////////////////////////////////////////
   // Bus handshake: reads take one wait state, long instructions stall the bus
   assign hreadyout = ~rd_wait_q & (state_q == MRRE_ST_IDLE);
   assign hresp = 1'b0;
   assign hrdata = hrdata_q;
   assign addr_take = hsel & htrans[1] & hready;
   assign wr_done = dphase_q & dwrite_q & hreadyout;
   assign exec_go = wr_done & (dreg_q == MRRE_R_INSTR);
   assign sw_wr = wr_done & (dreg_q != MRRE_R_INSTR);

   // Instruction fields seen by the execution unit; stack top loaded into the PC by returns
   assign instr = mrre_instr_t'(hwdata[15:0]);
   assign exec_addr = instr.operand[FILE_ADDR_W-1:0];
   assign stack_empty = (sp_q == SP_RST);
   assign stack_full = (sp_q == SP_W'(STACK_DEPTH));
   assign top_idx = STACK_IDX_W'(sp_q - 4'h1);
   assign stack_top = stack_empty ? PC_RST : stack_q[top_idx];

   mrre_exec_unit u_exec (
      .instr(instr),
      .work(work_q),
      .file_val(file_q[exec_addr]),
      .carry(carry_q),
      .fx(fx)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Address phase capture
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dphase_q <= 1'b0;
         dwrite_q <= 1'b0;
         dreg_q <= MRRE_R_NONE;
      end else if (hready) begin
         dphase_q <= addr_take;
         dwrite_q <= addr_take & hwrite;
         dreg_q <= mrre_reg_index(haddr[7:0]);
      end
   end

   // Read wait state: the data is sampled one cycle after the address phase,
   // so a write finishing at that same edge is already visible
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rd_wait_q <= 1'b0;
      end else if (addr_take & ~hwrite) begin
         rd_wait_q <= 1'b1;
      end else begin
         rd_wait_q <= 1'b0;
      end
   end

   // Read data register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_q <= 32'h0000_0000;
      end else if (rd_wait_q) begin
         hrdata_q <= rd_mux;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Read multiplexer; unmapped offsets and the instruction port read zero
   always_comb begin
      status_word = 32'h0000_0000;
      status_word[ST_CARRY_BIT] = carry_q;
      status_word[ST_ZERO_BIT] = zero_q;
      status_word[ST_IRQ_EN_BIT] = irq_en_q;
      status_word[ST_BUSY_BIT] = (state_q != MRRE_ST_IDLE);
      case (dreg_q)
         MRRE_R_WORK: rd_mux = {24'h00_0000, work_q};
         MRRE_R_STATUS: rd_mux = status_word;
         MRRE_R_PC: rd_mux = {21'h00_0000, pc_q};
         MRRE_R_STACK: rd_mux = {28'h000_0000, sp_q};
         MRRE_R_FADDR: rd_mux = {25'h000_0000, faddr_q};
         MRRE_R_FDATA: rd_mux = {24'h00_0000, file_q[faddr_q]};
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Sequencer: a two-cycle instruction holds the second cycle as a bus stall
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_q <= MRRE_ST_IDLE;
      end else begin
         case (state_q)
            MRRE_ST_IDLE: begin
               if (exec_go && fx.two_cycle) begin
                  state_q <= MRRE_ST_SECOND;
               end
            end
            MRRE_ST_SECOND: begin
               state_q <= MRRE_ST_IDLE;
            end
            default: begin
               state_q <= MRRE_ST_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Working register: instruction result or software write
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         work_q <= WORK_RST;
      end else if (exec_go && fx.work_we) begin
         work_q <= fx.work_d;
      end else if (sw_wr && dreg_q == MRRE_R_WORK) begin
         work_q <= hwdata[DATA_W-1:0];
      end
   end

   // Flags: only the flags an instruction names are touched
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         carry_q <= 1'b0;
         zero_q <= 1'b0;
         irq_en_q <= 1'b0;
      end else if (exec_go) begin
         if (fx.carry_we) begin
            carry_q <= fx.carry_d;
         end
         if (fx.zero_we) begin
            zero_q <= fx.zero_d;
         end
         if (fx.irq_en_set) begin
            irq_en_q <= 1'b1;
         end
      end else if (sw_wr && dreg_q == MRRE_R_STATUS) begin
         carry_q <= hwdata[ST_CARRY_BIT];
         zero_q <= hwdata[ST_ZERO_BIT];
         irq_en_q <= hwdata[ST_IRQ_EN_BIT];
      end
   end

   // Program counter: returns load the stack top, others step by one
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pc_q <= PC_RST;
      end else if (exec_go) begin
         if (fx.pop) begin
            pc_q <= stack_top;
         end else begin
            pc_q <= PC_W'(pc_q + 11'h001);
         end
      end else if (sw_wr && dreg_q == MRRE_R_PC) begin
         pc_q <= hwdata[PC_W-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Call stack: software pushes return addresses, returns pop them.
   // Push on a full stack and pop on an empty one are ignored.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sp_q <= SP_RST;
      end else if (exec_go && fx.pop && !stack_empty) begin
         sp_q <= SP_W'(sp_q - 4'h1);
      end else if (sw_wr && dreg_q == MRRE_R_STACK && !stack_full) begin
         sp_q <= SP_W'(sp_q + 4'h1);
      end
   end

   generate
      for (genvar i = 0; i < STACK_DEPTH; i++) begin : g_stack
         // One stack level, written only by a push landing on it
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               stack_q[i] <= PC_RST;
            end else if (sw_wr && dreg_q == MRRE_R_STACK && !stack_full &&
                         sp_q == SP_W'(i)) begin
               stack_q[i] <= hwdata[PC_W-1:0];
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // File register window address
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         faddr_q <= FADDR_RST;
      end else if (sw_wr && dreg_q == MRRE_R_FADDR) begin
         faddr_q <= hwdata[FILE_ADDR_W-1:0];
      end
   end

   // File registers; an instruction and a software access never share an edge
   generate
      for (genvar j = 0; j < FILE_DEPTH; j++) begin : g_file
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               file_q[j] <= FILE_RST;
            end else if (exec_go && fx.file_we && exec_addr == FILE_ADDR_W'(j)) begin
               file_q[j] <= fx.file_d;
            end else if (sw_wr && dreg_q == MRRE_R_FDATA && faddr_q == FILE_ADDR_W'(j)) begin
               file_q[j] <= hwdata[DATA_W-1:0];
            end
         end
      end
   endgenerate

endmodule

// file: design/mrre_exec_unit.sv
// Combinational execution unit: decodes one instruction word into its effects.
// Assumes the caller supplies the addressed file value and current carry flag.
`timescale 1ns/1ps

module mrre_exec_unit
   import mrre_pkg::*;
(
   input wire mrre_instr_t instr,
   input wire logic [DATA_W-1:0] work,
   input wire logic [DATA_W-1:0] file_val,
   input wire logic carry,
   output mrre_exec_t fx
);

   ////////////////////////////////////////////////////////////////////////////////
   // Decode; unknown opcodes behave as no operation
   always_comb begin
      fx = '0;
      case (instr.opcode)
         MRRE_OP_COPY_WORK_TO_FILE: begin
            fx.file_we = 1'b1;
            fx.file_d = work;
         end
         MRRE_OP_LOAD_LITERAL: begin
            fx.work_we = 1'b1;
            fx.work_d = instr.operand;
         end
         MRRE_OP_COPY_FILE_VALUE: begin
            fx.file_we = instr.dest;
            fx.work_we = ~instr.dest;
            fx.file_d = file_val;
            fx.work_d = file_val;
            fx.zero_we = 1'b1;
            fx.zero_d = (file_val == 8'h00);
         end
         MRRE_OP_RETURN_IRQ_REENABLE: begin
            fx.pop = 1'b1;
            fx.irq_en_set = 1'b1;
            fx.two_cycle = 1'b1;
         end
         MRRE_OP_RETURN_WITH_LITERAL: begin
            fx.work_we = 1'b1;
            fx.work_d = instr.operand;
            fx.pop = 1'b1;
            fx.two_cycle = 1'b1;
         end
         MRRE_OP_ROTATE_LEFT_CARRY: begin
            fx.file_we = instr.dest;
            fx.work_we = ~instr.dest;
            fx.file_d = {file_val[6:0], carry};
            fx.work_d = {file_val[6:0], carry};
            fx.carry_we = 1'b1;
            fx.carry_d = file_val[7];
         end
         default: begin
            fx = '0;
         end
      endcase
   end

endmodule

// file: design/mrre_pkg.sv
// Constants, types and register map of the move/return/rotate execution block.
// Assumes one 125 MHz core clock and an AHB-Lite port driven by a single master.
//
// How it works
// - copy_work_to_file writes working register into file register, flags kept, one cycle.
// - load_literal puts the 8-bit literal into working register, flags kept, one cycle.
// - copy_file_value moves file register to working register (d=0) or itself (d=1).
// - copy_file_value sets the zero flag when the moved value is zero, else clears it.
// - return_irq_reenable pops stack into program counter, sets interrupt enable, two cycles.
// - return_with_literal loads literal, pops stack into program counter, two cycles.
// - rotate_left_carry shifts left, carry into bit 0, bit 7 into carry, one cycle.
// - rotate_left_carry writes working register when d=0, file register when d=1.
package mrre_pkg;

   localparam int DATA_W = 8;
   localparam int FILE_ADDR_W = 7;
   localparam int FILE_DEPTH = 128;
   localparam int PC_W = 11;
   localparam int STACK_DEPTH = 8;
   localparam int STACK_IDX_W = 3;
   localparam int SP_W = 4;
   localparam int EXEC_LONG_CYCLES = 2;

   // Byte offsets, decoded on haddr[7:0]
   localparam logic [7:0] OFS_INSTR = 8'h00;
   localparam logic [7:0] OFS_WORK = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h08;
   localparam logic [7:0] OFS_PC = 8'h0c;
   localparam logic [7:0] OFS_STACK = 8'h10;
   localparam logic [7:0] OFS_FILE_ADDR = 8'h14;
   localparam logic [7:0] OFS_FILE_DATA = 8'h18;

   // Status register bit positions
   localparam int ST_CARRY_BIT = 0;
   localparam int ST_ZERO_BIT = 1;
   localparam int ST_IRQ_EN_BIT = 2;
   localparam int ST_BUSY_BIT = 3;

   // Reset values
   localparam logic [DATA_W-1:0] WORK_RST = 8'h00;
   localparam logic [DATA_W-1:0] FILE_RST = 8'h00;
   localparam logic [PC_W-1:0] PC_RST = 11'h000;
   localparam logic [SP_W-1:0] SP_RST = 4'h0;
   localparam logic [FILE_ADDR_W-1:0] FADDR_RST = 7'h00;

   // Opcodes in instruction bits [15:12]
   typedef enum logic [3:0] {
      MRRE_OP_NOP = 4'h0,
      MRRE_OP_COPY_WORK_TO_FILE = 4'h1,
      MRRE_OP_LOAD_LITERAL = 4'h2,
      MRRE_OP_COPY_FILE_VALUE = 4'h3,
      MRRE_OP_RETURN_IRQ_REENABLE = 4'h4,
      MRRE_OP_RETURN_WITH_LITERAL = 4'h5,
      MRRE_OP_ROTATE_LEFT_CARRY = 4'h6
   } mrre_op_t;

   typedef enum logic [0:0] {
      MRRE_ST_IDLE = 1'b0,
      MRRE_ST_SECOND = 1'b1
   } mrre_state_t;

   typedef enum logic [2:0] {
      MRRE_R_INSTR = 3'h0,
      MRRE_R_WORK = 3'h1,
      MRRE_R_STATUS = 3'h2,
      MRRE_R_PC = 3'h3,
      MRRE_R_STACK = 3'h4,
      MRRE_R_FADDR = 3'h5,
      MRRE_R_FDATA = 3'h6,
      MRRE_R_NONE = 3'h7
   } mrre_reg_t;

   // Instruction word: opcode, destination bit, spare, operand
   typedef struct packed {
      logic [3:0] opcode;
      logic dest;
      logic [2:0] spare;
      logic [DATA_W-1:0] operand;
   } mrre_instr_t;

   // Effects of one instruction, produced by the execution unit
   typedef struct packed {
      logic work_we;
      logic [DATA_W-1:0] work_d;
      logic file_we;
      logic [DATA_W-1:0] file_d;
      logic carry_we;
      logic carry_d;
      logic zero_we;
      logic zero_d;
      logic pop;
      logic irq_en_set;
      logic two_cycle;
   } mrre_exec_t;

   // Address decode shared by the read and write paths
   function automatic mrre_reg_t mrre_reg_index(input logic [7:0] a);
      mrre_reg_t r;
      r = MRRE_R_NONE;
      case (a)
         OFS_INSTR: r = MRRE_R_INSTR;
         OFS_WORK: r = MRRE_R_WORK;
         OFS_STATUS: r = MRRE_R_STATUS;
         OFS_PC: r = MRRE_R_PC;
         OFS_STACK: r = MRRE_R_STACK;
         OFS_FILE_ADDR: r = MRRE_R_FADDR;
         OFS_FILE_DATA: r = MRRE_R_FDATA;
         default: r = MRRE_R_NONE;
      endcase
      return r;
   endfunction

endpackage

// file: tb/mrre_core_props.sv
// Bus-side checker for the move/return/rotate block.
// Assumes a single master and hready tied to the slave's hreadyout.
`timescale 1ns/1ps

module mrre_core_props
   import mrre_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic [31:0] hrdata,
   input wire logic hresp
);
   logic wr_q;
   logic rd_q;
   logic irq_en_q;
   logic [7:0] ad_q;
   logic take;
   logic ex;
   logic quiet;
   logic [3:0] op;

   ////////////////////////////////////////
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   // Instruction executes when its write data phase completes
   assign take = hsel && htrans[1] && hready;
   assign ex = wr_q && hreadyout && ad_q == OFS_INSTR;
   assign op = hwdata[15:12];
   assign quiet = !(take && !hwrite); // A read taken here would add its own wait

   // Data phase tracking; the address phase only moves on when hready is high
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_q <= 1'b0;
         rd_q <= 1'b0;
         ad_q <= 8'h00;
      end else if (hready) begin
         wr_q <= take && hwrite;
         rd_q <= take && !hwrite;
         ad_q <= haddr[7:0];
      end
   end

   // Expected interrupt enable: set by the return, else as software wrote it
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_en_q <= 1'b0;
      end else if (ex && op == MRRE_OP_RETURN_IRQ_REENABLE) begin
         irq_en_q <= 1'b1;
      end else if (wr_q && hreadyout && ad_q == OFS_STATUS) begin
         irq_en_q <= hwdata[ST_IRQ_EN_BIT];
      end
   end

   ////////////////////////////////////////
   cwf_one_cycle_a: assert property (ex && op == MRRE_OP_COPY_WORK_TO_FILE
      && quiet |=> hreadyout)
      else $error("copy to file stalled");
   lit_one_cycle_a: assert property (ex && op == MRRE_OP_LOAD_LITERAL
      && quiet |=> hreadyout)
      else $error("load literal stalled");
   cfv_one_cycle_a: assert property (ex && op == MRRE_OP_COPY_FILE_VALUE
      && quiet |=> hreadyout)
      else $error("copy file value stalled");
   rlc_one_cycle_a: assert property (ex && op == MRRE_OP_ROTATE_LEFT_CARRY
      && quiet |=> hreadyout)
      else $error("rotate stalled");
   irqret_two_cycle_a: assert property (ex && op == MRRE_OP_RETURN_IRQ_REENABLE
      |=> !hreadyout ##1 hreadyout)
      else $error("interrupt return not two cycles");
   retlit_two_cycle_a: assert property (ex && op == MRRE_OP_RETURN_WITH_LITERAL
      |=> !hreadyout ##1 hreadyout)
      else $error("literal return not two cycles");
   irq_en_readback_a: assert property (rd_q && hreadyout && ad_q == OFS_STATUS
      |-> hrdata[ST_IRQ_EN_BIT] == irq_en_q)
      else $error("interrupt enable bit wrong");
   nop_one_cycle_a: assert property (ex && op == 4'hf && quiet |=> hreadyout)
      else $error("unknown opcode stalled");
endmodule

bind mrre_core mrre_core_props mrre_core_props_inst (.hclk, .hresetn, .hsel, .haddr, .htrans,
   .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hrdata, .hresp);

// file: tb/testbench.sv
// Self-checking bench: drives instructions and register accesses over AHB-Lite.
// Assumes one slave, so hready is the block's own hreadyout.
`timescale 1ns/1ps

module testbench
   import mrre_pkg::*;
;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, hready;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [2:0] hsize;
   int error_cnt, comparisons;

   assign hready = hreadyout;
   mrre_core mrre_core_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
      .hwdata, .hready, .hreadyout, .hrdata, .hresp);

   // 125 MHz core clock
   initial begin
      hclk = 1'b0;
      forever #4 hclk = ~hclk;
   end

   ////////////////////////////////////////
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD %s exp %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic final_report;
      $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // Bounded wait for hready at a rising edge; a hang ends the run
   task automatic wait_rdy;
      int n;
      n = 0;
      @(posedge hclk);
      while (hready !== 1'b1) begin
         n++;
         if (n > 16) begin
            error_cnt++;
            $display("BAD hready exp 1 seen %b", hready);
            final_report;
         end
         @(posedge hclk);
      end
   endtask

   // One single transfer: address phase, then data phase; read data lands in rd
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'b10;
      hwrite <= w;
      wait_rdy;
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      wait_rdy;
      rd = hrdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask

   task automatic run(input logic [15:0] i);
      bus(1'b1, OFS_INSTR, {16'h0, i});
   endtask

   task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      check(nm, rd, exp);
   endtask

   // Leaves the file pointer on the location just written
   task automatic file_set(input logic [7:0] a, input logic [7:0] v);
      wr(OFS_FILE_ADDR, {24'h0, a});
      wr(OFS_FILE_DATA, {24'h0, v});
   endtask

   ////////////////////////////////////////
   initial begin
      error_cnt = 0;
      comparisons = 0;
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rchk("work", OFS_WORK, 32'h0);
      rchk("pc", OFS_PC, 32'h0);
      rchk("unmapped", 8'h1c, 32'h0);
      $display("reset test done");
      // Carry preset so that flagless instructions can be seen to keep it
      wr(OFS_STATUS, 32'h1);
      wr(OFS_PC, 32'h100);
      run(16'h2055);
      rchk("work", OFS_WORK, 32'h55);
      rchk("status", OFS_STATUS, 32'h1);
      rchk("pc", OFS_PC, 32'h101);
      $display("literal test done");
      run(16'h20aa);
      file_set(8'h7f, 8'h55);
      run(16'h107f);
      rchk("file", OFS_FILE_DATA, 32'haa);
      rchk("status", OFS_STATUS, 32'h1);
      $display("copy to file test done");
      file_set(8'h10, 8'h00);
      run(16'h3010);
      rchk("work", OFS_WORK, 32'h0);
      rchk("status", OFS_STATUS, 32'h3);
      file_set(8'h11, 8'h80);
      run(16'h3811);
      rchk("work", OFS_WORK, 32'h0);
      rchk("file", OFS_FILE_DATA, 32'h80);
      rchk("status", OFS_STATUS, 32'h1);
      $display("copy file test done");
      // Zero preset, carry clear: only carry may move
      wr(OFS_STATUS, 32'h2);
      file_set(8'h20, 8'ha5);
      run(16'h6820);
      rchk("file", OFS_FILE_DATA, 32'h4a);
      rchk("status", OFS_STATUS, 32'h3);
      rchk("work", OFS_WORK, 32'h0);
      run(16'h6020);
      rchk("work", OFS_WORK, 32'h95);
      rchk("file", OFS_FILE_DATA, 32'h4a);
      rchk("status", OFS_STATUS, 32'h2);
      $display("rotate test done");
      wr(OFS_STACK, 32'h123);
      wr(OFS_STACK, 32'h456);
      run(16'h4000);
      rchk("pc", OFS_PC, 32'h456);
      rchk("sp", OFS_STACK, 32'h1);
      rchk("status", OFS_STATUS, 32'h6);
      // Unknown opcode right behind the two-cycle return
      run(16'h5033);
      run(16'hf000);
      rchk("work", OFS_WORK, 32'h33);
      rchk("pc", OFS_PC, 32'h124);
      rchk("sp", OFS_STACK, 32'h0);
      rchk("status", OFS_STATUS, 32'h6);
      $display("return test done");
      final_report;
   end
endmodule
